// File: tof_pin_ctrl.sv
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "tof_cfg.svh"

module tof_pin_ctrl #(
  parameter int TICK_CYCLES = `TOF_CLK_KHZ * `TOF_TICK_US / 1000
) (
  input wire logic core_clk_i,                   // 25 MHz clock
  input wire logic reset_i,                      // async reset, high
  input wire logic [3:0] reg_addr_i,             // register address
  input wire logic [7:0] reg_wdata_i,            // write data
  input wire logic reg_wr_i,                     // write strobe
  input wire logic reg_rd_i,                     // read strobe
  output logic [7:0] reg_rdata_o,                // read data, next cycle
  input wire logic enable_pin_one_i,             // pin one level
  input wire logic enable_pin_two_i,             // pin two level
  output logic enable_pin_two_o,                 // pin two drive, reset high
  output logic enable_pin_two_oe_o,              // pin two driven
  input wire logic enable_pin_three_i,           // pin three level
  output tof_pkg::tof_run_t out_run_o,           // per-output run
  output logic lf_clk_run_o,                     // 32 kHz clock runs
  output logic power_down_o,                     // lowest power state
  output logic [2:0] out_power_saving_o,         // saving inputs out1..3
  output logic [1:0] frequency_profile_select_o, // second pll profile
  output logic irq_o                             // level interrupt
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  tof_pkg::tof_ctrl_t ctrl;
  tof_pkg::tof_ctrl_t wr_val;
  tof_pkg::tof_pinfn_t pinfn;
  tof_pkg::tof_status_t status;
  tof_pkg::tof_tstate_t tstate;
  tof_pkg::tof_run_t next_run;
  logic [4:0] out_en;
  logic [1:0] prof_reg;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] pins;
  logic wr_ctrl;
  logic timer_kick;
  logic flag_clear;
  logic tick;
  logic [`TOF_MS_W-1:0] ms_count;
  logic [`TOF_MS_W-1:0] ms_last;
  logic expire;
  logic timeout_flag;
  logic [`TOF_RST_W-1:0] rst_count;
  logic pulse_active;
  logic pulse_end;
  logic prof_force;
  logic prof_clear;
  logic [1:0] next_profile;
  logic next_down;
  logic down_enter;
  logic out1_gate;
  logic out2_gate;
  logic out3_gate;
  logic diff_gate;
  logic [2:0] next_saving;
  logic [`TOF_IRQ_W-1:0] irq_stat;
  logic [`TOF_IRQ_W-1:0] irq_en;
  logic [`TOF_IRQ_W-1:0] irq_event;
  logic [`TOF_IRQ_W-1:0] irq_clr;
  logic [7:0] next_rdata;

  localparam logic [`TOF_RST_W-1:0] RST_LAST = `TOF_RST_W'(`TOF_RST_MS - 1);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  assign pins = {enable_pin_three_i, enable_pin_two_i, enable_pin_one_i};

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_sync
      always_ff @(posedge core_clk_i or posedge reset_i)
      begin
        if (reset_i)
        begin
          pin_meta[g] <= 1'b1;
          pin_sync[g] <= 1'b1;
        end
        else
        begin
          pin_meta[g] <= pins[g];
          pin_sync[g] <= pin_meta[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  assign wr_val = tof_pkg::tof_ctrl_t'(reg_wdata_i);
  assign wr_ctrl = reg_wr_i && (reg_addr_i == `TOF_A_CTRL);
  assign timer_kick = wr_ctrl && wr_val.tmr_en;
  assign flag_clear = wr_ctrl && !wr_val.tmr_en;

  // a software write in the same cycle beats the hardware disable
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      ctrl <= tof_pkg::tof_ctrl_t'(`TOF_CTRL_RST);
    else if (wr_ctrl)
      ctrl <= wr_val;
    else if (prof_clear)
      ctrl.prof_en <= 1'b0;
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      pinfn <= tof_pkg::tof_pinfn_t'(`TOF_PINFN_RST);
    else if (reg_wr_i && (reg_addr_i == `TOF_A_PINFN))
      pinfn <= tof_pkg::tof_pinfn_t'(reg_wdata_i);
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      out_en <= `TOF_OUTEN_RST;
      prof_reg <= 2'h0;
      irq_en <= '0;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == `TOF_A_OUTEN)
        out_en <= reg_wdata_i[4:0];
      if (reg_addr_i == `TOF_A_PROF)
        prof_reg <= reg_wdata_i[1:0];
      if (reg_addr_i == `TOF_A_IRQE)
        irq_en <= reg_wdata_i[`TOF_IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // millisecond time base, realigned on each kick
  // ----------------------------------------------------------------
  tof_tick_div #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .clear_i(timer_kick),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // timeout timer
  // ----------------------------------------------------------------
  always_comb
  begin
    case (ctrl.to_sel)
      2'h0: ms_last = `TOF_MS_W'(`TOF_TO0_MS - 1);
      2'h1: ms_last = `TOF_MS_W'(`TOF_TO1_MS - 1);
      2'h2: ms_last = `TOF_MS_W'(`TOF_TO2_MS - 1);
      default: ms_last = `TOF_MS_W'(`TOF_TO3_MS - 1);
    endcase
  end

  assign expire = (tstate == tof_pkg::TOF_TS_RUN) && tick && (ms_count == ms_last) && !timer_kick;

  // writing one again restarts the count, watchdog style
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      tstate <= tof_pkg::TOF_TS_IDLE;
      ms_count <= '0;
    end
    else if (timer_kick)
    begin
      tstate <= tof_pkg::TOF_TS_RUN;
      ms_count <= '0;
    end
    else if (!ctrl.tmr_en)
    begin
      tstate <= tof_pkg::TOF_TS_IDLE;
      ms_count <= '0;
    end
    else
    begin
      case (tstate)
        tof_pkg::TOF_TS_RUN:
        begin
          if (expire)
            tstate <= tof_pkg::TOF_TS_DONE;
          else if (tick)
            ms_count <= ms_count + 1'b1;
        end
        tof_pkg::TOF_TS_DONE:
          tstate <= tof_pkg::TOF_TS_DONE;
        tof_pkg::TOF_TS_IDLE:
          tstate <= tof_pkg::TOF_TS_IDLE;
        default:
          tstate <= tof_pkg::TOF_TS_IDLE;
      endcase
    end
  end

  // expiry wins over a clearing write in the same cycle
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      timeout_flag <= 1'b0;
    else if (expire)
      timeout_flag <= 1'b1;
    else if (flag_clear)
      timeout_flag <= 1'b0;
  end

  // ----------------------------------------------------------------
  // reset-out pulse
  // ----------------------------------------------------------------
  assign pulse_end = pulse_active && tick && (rst_count == RST_LAST);

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pulse_active <= 1'b0;
      rst_count <= '0;
    end
    else if (expire && ctrl.rst_en && !pulse_active)
    begin
      pulse_active <= 1'b1;
      rst_count <= '0;
    end
    else if (pulse_end)
      pulse_active <= 1'b0;
    else if (pulse_active && tick)
      rst_count <= rst_count + 1'b1;
  end

  // ----------------------------------------------------------------
  // profile reversion and selection
  // ----------------------------------------------------------------
  // without a pulse the selection is dropped right at expiry
  assign prof_clear = (expire && ctrl.prof_en && !ctrl.rst_en) || (pulse_end && prof_force);

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      prof_force <= 1'b0;
    else if (expire && ctrl.prof_en)
      prof_force <= 1'b1;
    else if (pulse_end || !ctrl.prof_en)
      prof_force <= 1'b0;
  end

  // pin three alone is not a legal pin mode, so registers steer
  always_comb
  begin
    next_profile = prof_reg;
    if (!ctrl.prof_en || prof_force)
      next_profile = 2'h0;
    else if (pinfn.fn1 == tof_pkg::TOF_FN_AUX)
    begin
      next_profile[0] = pin_sync[0];
      next_profile[1] = (pinfn.fn3 == tof_pkg::TOF_FN_AUX) && pin_sync[2];
    end
  end

  // ----------------------------------------------------------------
  // output gating
  // ----------------------------------------------------------------
  assign out1_gate = (pinfn.fn1 != tof_pkg::TOF_FN_OE) || pin_sync[0];
  assign out2_gate = (pinfn.fn2 != tof_pkg::TOF_FN_OE) || pin_sync[1];
  assign diff_gate = (pinfn.fn2 != tof_pkg::TOF_FN_ALT) || pin_sync[1];
  assign out3_gate = (pinfn.fn3 != tof_pkg::TOF_FN_OE) || pin_sync[2];
  assign next_down = (pinfn.fn1 == tof_pkg::TOF_FN_ALT) && !pin_sync[0];

  always_comb
  begin
    next_run.se[0] = out1_gate && out_en[0];
    next_run.se[1] = out2_gate && out_en[1];
    next_run.se[2] = out3_gate && out_en[2];
    next_run.diff[0] = diff_gate && out_en[3];
    next_run.diff[1] = diff_gate && out_en[4];
    if (next_down || !ctrl.oe_en)
      next_run = '0;
  end

  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_save
      // the pin follows the end device clock; analog side swaps sources
      assign next_saving[g] = (pinfn[2*g +: 2] == tof_pkg::TOF_FN_SAVE) && pin_sync[g];
    end
  endgenerate

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      out_run_o <= '0;
      power_down_o <= 1'b0;
      out_power_saving_o <= 3'h0;
      frequency_profile_select_o <= 2'h0;
      enable_pin_two_o <= 1'b1;
      enable_pin_two_oe_o <= 1'b0;
    end
    else
    begin
      out_run_o <= next_run;
      power_down_o <= next_down;
      out_power_saving_o <= next_saving;
      frequency_profile_select_o <= next_profile;
      enable_pin_two_o <= !pulse_active;
      enable_pin_two_oe_o <= (pinfn.fn2 == tof_pkg::TOF_FN_AUX);
    end
  end

  // low-frequency clock is never gated, even in power-down
  assign lf_clk_run_o = 1'b1;

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign down_enter = next_down && !power_down_o;
  assign irq_event = {down_enter, pulse_end, expire};
  assign irq_clr = (reg_wr_i && (reg_addr_i == `TOF_A_IRQC)) ?
                   reg_wdata_i[`TOF_IRQ_W-1:0] : '0;

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      irq_stat <= '0;
    else
      irq_stat <= (irq_stat & ~irq_clr) | irq_event;
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(((irq_stat & ~irq_clr) | irq_event) & irq_en);
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_comb
  begin
    status = '0;
    status.flag = timeout_flag;
    status.running = (tstate == tof_pkg::TOF_TS_RUN);
    status.pulse = pulse_active;
    status.pwr_down = power_down_o;
    status.profile = frequency_profile_select_o;
  end

  always_comb
  begin
    case (reg_addr_i)
      `TOF_A_CTRL: next_rdata = ctrl;
      `TOF_A_PINFN: next_rdata = pinfn;
      `TOF_A_OUTEN: next_rdata = {3'h0, out_en};
      `TOF_A_PROF: next_rdata = {6'h00, prof_reg};
      `TOF_A_STAT: next_rdata = status;
      `TOF_A_IRQS: next_rdata = {5'h00, irq_stat};
      `TOF_A_IRQE: next_rdata = {5'h00, irq_en};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
      reg_rdata_o <= next_rdata;
    else
      reg_rdata_o <= 8'h00;
  end

endmodule

// File: tof_cfg.svh
// How it works
// - timeouts of 0.5, 1, 2 or 4 seconds
// - timeout flag holds until enable written zero
// - expiry with reset enabled: one 250 ms pulse
// - expiry forces profile zero, then disables selection
// - pin one gates single-ended out1 only
// - pin two gates out2 or both differentials
// - pin three gates single-ended out3 only
// - pin one power-down low: all stop but 32k
// - pins one and three give profile select bits
// - each pin may be its output's saving input
// - pin two alone may drive reset-out pulse
// - every pin resets to plain output-enable function
`ifndef TOF_CFG_SVH
`define TOF_CFG_SVH

// ----------------------------------------------------------------
// time base
// ----------------------------------------------------------------
`define TOF_CLK_KHZ 25000
`define TOF_TICK_US 1000
`define TOF_TO0_MS 500
`define TOF_TO1_MS 1000
`define TOF_TO2_MS 2000
`define TOF_TO3_MS 4000
`define TOF_RST_MS 250
`define TOF_MS_W 13
`define TOF_RST_W 8

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TOF_A_CTRL 4'h0
`define TOF_A_PINFN 4'h1
`define TOF_A_OUTEN 4'h2
`define TOF_A_PROF 4'h3
`define TOF_A_STAT 4'h4
`define TOF_A_IRQS 4'h5
`define TOF_A_IRQC 4'h6
`define TOF_A_IRQE 4'h7

// ----------------------------------------------------------------
// reset values and interrupt width
// ----------------------------------------------------------------
`define TOF_CTRL_RST 8'h01
`define TOF_PINFN_RST 8'h00
`define TOF_OUTEN_RST 5'h1f
`define TOF_IRQ_W 3

`endif

// File: tof_pkg.sv
package tof_pkg;

  // pin function codes; meaning of alt and aux differs per pin
  typedef enum logic [1:0] {
    TOF_FN_OE = 2'b00,
    TOF_FN_ALT = 2'b01,
    TOF_FN_SAVE = 2'b10,
    TOF_FN_AUX = 2'b11
  } tof_fn_t;

  typedef enum logic [1:0] {
    TOF_TS_IDLE = 2'b00,
    TOF_TS_RUN = 2'b01,
    TOF_TS_DONE = 2'b10
  } tof_tstate_t;

  typedef struct packed {
    logic [1:0] rsv;
    logic prof_en;
    logic rst_en;
    logic [1:0] to_sel;
    logic tmr_en;
    logic oe_en;
  } tof_ctrl_t;

  typedef struct packed {
    logic [1:0] rsv;
    tof_fn_t fn3;
    tof_fn_t fn2;
    tof_fn_t fn1;
  } tof_pinfn_t;

  typedef struct packed {
    logic [1:0] diff;
    logic [2:0] se;
  } tof_run_t;

  typedef struct packed {
    logic [1:0] rsv;
    logic [1:0] profile;
    logic pwr_down;
    logic pulse;
    logic running;
    logic flag;
  } tof_status_t;

endpackage

// File: tof_tick_div.sv
`timescale 1ns/1ps

module tof_tick_div #(
  parameter int CYCLES = 25000
) (
  input wire logic core_clk_i, // clock
  input wire logic reset_i,    // async reset, high
  input wire logic clear_i,    // restart the period
  output logic tick_o          // one-cycle pulse per period
);

  localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] count;

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      count <= '0;
      tick_o <= 1'b0;
    end
    else if (clear_i)
    begin
      count <= '0;
      tick_o <= 1'b0;
    end
    else if (count == LAST)
    begin
      count <= '0;
      tick_o <= 1'b1;
    end
    else
    begin
      count <= count + 1'b1;
      tick_o <= 1'b0;
    end
  end

endmodule

// File: tof_pin_ctrl_properties.sv
`timescale 1ns/1ps
`include "tof_cfg.svh"

module tof_pin_ctrl_properties #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic core_clk_i, // clock
  input wire logic reset_i, // async reset
  input wire logic [3:0] reg_addr_i, // address
  input wire logic [7:0] reg_wdata_i, // write data
  input wire logic reg_wr_i, // write strobe
  input wire logic enable_pin_one_i, // pin one
  input wire logic enable_pin_two_i, // pin two
  input wire logic enable_pin_three_i, // pin three
  input wire logic enable_pin_two_o, // pin two drive
  input wire logic enable_pin_two_oe_o, // pin two driven
  input tof_pkg::tof_run_t out_run_o, // output runs
  input wire logic lf_clk_run_o, // 32k runs
  input wire logic power_down_o, // lowest power
  input wire logic [2:0] out_power_saving_o // saving inputs
);
  localparam int PULSE = `TOF_RST_MS * TICK_CYCLES;
  logic [5:0] fn;
  logic [31:0] low_cnt;

  // ----
  // pin functions as software last wrote them
  // ----
  always_ff @(posedge core_clk_i or posedge reset_i)
    if (reset_i)
      fn <= 6'h00;
    else if (reg_wr_i && reg_addr_i == `TOF_A_PINFN)
      fn <= reg_wdata_i[5:0];

  always_ff @(posedge core_clk_i or posedge reset_i)
    if (reset_i)
      low_cnt <= 32'h0;
    else
      low_cnt <= enable_pin_two_o ? 32'h0 : low_cnt + 32'h1;

  // ----
  // properties
  // ----
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  // pin level needs two sync flops and one output flop
  sequence down_held;
    (fn[1:0] == tof_pkg::TOF_FN_ALT && !enable_pin_one_i) [*4];
  endsequence
  sequence out1_held;
    (fn[1:0] == tof_pkg::TOF_FN_OE && !enable_pin_one_i) [*4];
  endsequence

  lf_run_a: assert property (lf_clk_run_o)
    else $error("slow clock stopped");
  down_stop_a: assert property (power_down_o |-> out_run_o == 5'h00)
    else $error("output runs in power-down");
  down_entry_a: assert property (down_held |-> power_down_o)
    else $error("power-down pin ignored");
  out1_gate_a: assert property (out1_held |-> !out_run_o.se[0])
    else $error("out1 runs with pin one low");
  diff_gate_a: assert property ((fn[3:2] == 2'b01 && !enable_pin_two_i) [*4]
    |-> out_run_o.diff == 2'b00) else $error("differential runs with pin two low");
  out3_gate_a: assert property ((fn[5:4] == 2'h0 && !enable_pin_three_i) [*4]
    |-> !out_run_o.se[2]) else $error("out3 runs with pin three low");
  pin2_dir_a: assert property (enable_pin_two_oe_o == ($past(fn[3:2]) == 2'b11))
    else $error("pin two direction wrong");
  save_map_a: assert property ($stable(fn[1:0]) [*4] |->
    out_power_saving_o[0] == (fn[1:0] == 2'b10 && $past(enable_pin_one_i, 3)))
    else $error("saving input one wrong");
  pulse_len_a: assert property ($rose(enable_pin_two_o) |-> low_cnt == PULSE)
    else $error("reset pulse length wrong");
endmodule

bind tof_pin_ctrl tof_pin_ctrl_properties #(.TICK_CYCLES(TICK_CYCLES)) u_tof_pin_ctrl_properties (
  .core_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .enable_pin_one_i,
  .enable_pin_two_i, .enable_pin_three_i, .enable_pin_two_o, .enable_pin_two_oe_o,
  .out_run_o, .lf_clk_run_o, .power_down_o, .out_power_saving_o);

// File: tof_board_model.sv
`timescale 1ns/1ps

module tof_board_model (
  input wire logic core_clk_i, // clock
  input wire logic [2:0] want_i, // levels the board drives
  input wire logic two_o_i, // device drive of pin two
  input wire logic two_oe_i, // device drives pin two
  output logic [2:0] pin_o, // wire levels
  output logic [31:0] low_len_o // last low time of pin two
);
  logic [31:0] cnt;

  initial
  begin
    cnt = 32'h0;
    low_len_o = 32'h0;
  end

  // board lets go of pin two while the device drives it
  assign pin_o = {want_i[2], two_oe_i ? two_o_i : want_i[1], want_i[0]};

  always @(posedge core_clk_i)
  begin
    cnt <= pin_o[1] ? 32'h0 : cnt + 32'h1;
    if (pin_o[1] && cnt != 32'h0)
      low_len_o <= cnt;
  end
endmodule

// File: test_tof_pin_ctrl.sv
`timescale 1ns/1ps
`include "tof_cfg.svh"

module test_tof_pin_ctrl;
  localparam int TICK = 4;
  logic core_clk_i, reset_i, reg_wr_i, reg_rd_i, enable_pin_two_o, enable_pin_two_oe_o;
  logic lf_clk_run_o, power_down_o, irq_o;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o;
  logic [2:0] want, pin, out_power_saving_o;
  logic [1:0] frequency_profile_select_o;
  logic [31:0] low_len;
  tof_pkg::tof_run_t out_run_o;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] rv [9] = '{8'h01, 8'h00, 8'h1f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [2:0] gp [3] = '{3'b110, 3'b101, 3'b011};
  logic [7:0] ge [3] = '{8'h1e, 8'h1d, 8'h1b};

  tof_pin_ctrl #(.TICK_CYCLES(TICK)) u_tof_pin_ctrl (.core_clk_i, .reset_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .enable_pin_one_i(pin[0]),
    .enable_pin_two_i(pin[1]), .enable_pin_two_o, .enable_pin_two_oe_o,
    .enable_pin_three_i(pin[2]), .out_run_o, .lf_clk_run_o, .power_down_o,
    .out_power_saving_o, .frequency_profile_select_o, .irq_o);
  tof_board_model u_tof_board_model (.core_clk_i, .want_i(want), .two_o_i(enable_pin_two_o),
    .two_oe_i(enable_pin_two_oe_o), .pin_o(pin), .low_len_o(low_len));

  initial
  begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  // ----
  // bus and check tasks
  // ----
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string what);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, input string w);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk({8'h00, reg_rdata_o & m}, {8'h00, e}, w);
  endtask

  // pins settle after two sync flops and the output flop
  task automatic pins(input logic [2:0] v);
    @(posedge core_clk_i);
    want <= v;
    repeat (5) @(posedge core_clk_i);
    #1;
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_fail++;
      $display("Error at %0t: run did not finish", $time);
      end_of_test();
    end
  end

  // ----
  // tests
  // ----
  initial
  begin
    reset_i = 1'b1;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    want = 3'b111;
    repeat (10) @(posedge core_clk_i);
    reset_i <= 1'b0;
    pins(3'b111);
    chk({9'h0, lf_clk_run_o, enable_pin_two_oe_o, out_run_o}, 16'h005f, "reset pins");
    for (int a = 0; a < 9; a++)
      rd(a[3:0], 8'hff, rv[a], "reset value");
    wr(`TOF_A_STAT, 8'hff);
    rd(`TOF_A_STAT, 8'hff, 8'h00, "read-only status");
    $display("reset test done");
    for (int i = 0; i < 3; i++)
    begin
      pins(gp[i]);
      chk({11'h0, out_run_o}, {8'h00, ge[i]}, "pin gate");
    end
    wr(`TOF_A_PINFN, 8'h04);
    pins(3'b101);
    chk({11'h0, out_run_o}, 16'h0007, "differential gate");
    wr(`TOF_A_OUTEN, 8'h1e);
    pins(3'b111);
    chk({11'h0, out_run_o}, 16'h001e, "output enable bit");
    wr(`TOF_A_OUTEN, 8'h1f);
    wr(`TOF_A_CTRL, 8'h00);
    pins(3'b111);
    chk({11'h0, out_run_o}, 16'h0000, "global enable");
    wr(`TOF_A_CTRL, 8'h01);
    $display("gating test done");
    wr(`TOF_A_PINFN, 8'h01);
    wr(`TOF_A_IRQC, 8'h07);
    pins(3'b110);
    chk({9'h0, lf_clk_run_o, power_down_o, out_run_o}, 16'h0060, "power-down");
    rd(`TOF_A_IRQS, 8'h04, 8'h04, "power-down event");
    pins(3'b111);
    chk({10'h0, power_down_o, out_run_o}, 16'h001f, "power-up");
    wr(`TOF_A_IRQC, 8'h07);
    $display("power-down test done");
    wr(`TOF_A_PINFN, 8'h2a);
    pins(3'b101);
    chk({8'h0, out_power_saving_o, out_run_o}, 16'h00bf, "saving inputs");
    wr(`TOF_A_PINFN, 8'h33);
    wr(`TOF_A_CTRL, 8'h21);
    pins(3'b100);
    chk({14'h0, frequency_profile_select_o}, 16'h0002, "profile pins");
    pins(3'b001);
    chk({14'h0, frequency_profile_select_o}, 16'h0001, "profile pins");
    wr(`TOF_A_CTRL, 8'h01);
    pins(3'b111);
    chk({14'h0, frequency_profile_select_o}, 16'h0000, "profile off");
    $display("pin function test done");
    wr(`TOF_A_PINFN, 8'h0c);
    wr(`TOF_A_PROF, 8'h03);
    wr(`TOF_A_CTRL, 8'h21);
    wr(`TOF_A_IRQE, 8'h03);
    pins(3'b111);
    chk({13'h0, enable_pin_two_oe_o, frequency_profile_select_o}, 16'h0007, "reset-out set");
    wr(`TOF_A_CTRL, 8'h33);
    repeat (`TOF_TO0_MS * TICK + 10) @(posedge core_clk_i);
    #1;
    chk({12'h0, irq_o, pin[1], frequency_profile_select_o}, 16'h0008, "expiry");
    for (int k = 0; k < 1200 && pin[1] !== 1'b1; k++)
      @(posedge core_clk_i);
    #2;
    chk(low_len[15:0], 16'(`TOF_RST_MS * TICK), "reset pulse length");
    rd(`TOF_A_CTRL, 8'h20, 8'h00, "profile select after pulse");
    rd(`TOF_A_STAT, 8'h01, 8'h01, "flag holds");
    rd(`TOF_A_IRQS, 8'h03, 8'h03, "timer events");
    wr(`TOF_A_IRQC, 8'h03);
    rd(`TOF_A_IRQS, 8'h03, 8'h00, "events cleared");
    chk({15'h0, irq_o}, 16'h0000, "interrupt low");
    wr(`TOF_A_CTRL, 8'h01);
    rd(`TOF_A_STAT, 8'h01, 8'h00, "flag cleared");
    $display("reset pulse test done");
    for (int s = 0; s < 4; s++)
    begin
      wr(`TOF_A_CTRL, 8'h23 | 8'(s << 2));
      repeat (TICK * (`TOF_TO0_MS << s) - 6) @(posedge core_clk_i);
      rd(`TOF_A_STAT, 8'h33, 8'h32, "still counting");
      repeat (6) @(posedge core_clk_i);
      rd(`TOF_A_STAT, 8'h33, 8'h01, "timed out");
      rd(`TOF_A_CTRL, 8'h20, 8'h00, "selection dropped at expiry");
      wr(`TOF_A_CTRL, 8'h01);
    end
    $display("timeout test done");
    end_of_test();
  end
endmodule
